// File: core/cdw_engine.sv
// capture descriptor queue, frame data routing and descriptor write-back
`timescale 1ns/1ps
module cdw_engine (
	// clock and reset
	input  wire logic                       mclk,
	input  wire logic                       rstn,
	// descriptor queue from software
	input  wire logic                       desc_valid,
	output logic                            desc_ready,
	input  wire logic [cdw_pkg::CHAN_W-1:0] desc_chan,
	input  wire cdw_pkg::cdw_desc_t         desc_in,
	// capture stream
	input  wire logic                       cap_valid,
	output logic                            cap_ready,
	input  wire logic [cdw_pkg::CHAN_W-1:0] cap_chan,
	input  wire logic                       cap_sof,
	input  wire logic                       cap_eof,
	input  wire logic [cdw_pkg::DATA_W-1:0] cap_data,
	input  wire logic [cdw_pkg::SIZE_W-1:0] cap_width,
	input  wire logic [cdw_pkg::SIZE_W-1:0] cap_height,
	// frame data to memory
	output logic                            mem_valid,
	input  wire logic                       mem_ready,
	output cdw_pkg::cdw_mem_t               mem_out,
	// descriptor write-back to memory
	output logic                            wb_valid,
	input  wire logic                       wb_ready,
	output cdw_pkg::cdw_wb_t                wb_out,
	// status
	output logic                            drop_pulse
);
	// per-channel descriptor queue
	cdw_pkg::cdw_desc_t              q_mem_r [cdw_pkg::NUM_CHAN][cdw_pkg::QUEUE_DEPTH];
	logic [cdw_pkg::QPTR_W-1:0]      q_rd_r  [cdw_pkg::NUM_CHAN];
	logic [cdw_pkg::QPTR_W-1:0]      q_wr_r  [cdw_pkg::NUM_CHAN];
	logic [cdw_pkg::QCNT_W-1:0]      q_cnt_r [cdw_pkg::NUM_CHAN];
	// frame state
	cdw_pkg::cdw_state_t             state_r;
	logic [cdw_pkg::CHAN_W-1:0]      chan_r;
	logic                            keep_r;
	logic [cdw_pkg::ADDR_W-1:0]      addr_r;
	// two-entry data buffer
	cdw_pkg::cdw_mem_t               buf_r [cdw_pkg::BUF_DEPTH];
	logic                            bwr_r;
	logic                            brd_r;
	logic [1:0]                      bcnt_r;
	// write-back register
	logic                            wb_valid_r;
	cdw_pkg::cdw_wb_t                wb_r;
	logic                            drop_r;

	logic                            beat;
	logic                            sof_beat;
	logic                            keep_now;
	logic [cdw_pkg::CHAN_W-1:0]      cur_chan;
	logic                            data_push;
	logic                            data_pop;
	logic                            consume;
	logic                            buf_full;
	logic [cdw_pkg::ADDR_W-1:0]      cur_addr;
	cdw_pkg::cdw_desc_t              head;

	function automatic logic has_desc(input logic [cdw_pkg::QCNT_W-1:0] cnt);
		has_desc = (cnt != 2'h0);
	endfunction : has_desc

	assign buf_full   = (bcnt_r == 2'h2);
	// a frame end must wait for a free write-back slot so no record is lost
	assign cap_ready  = !buf_full && !(cap_eof && wb_valid_r && !wb_ready);
	assign beat       = cap_valid && cap_ready;
	assign sof_beat   = beat && cap_sof;
	assign cur_chan   = sof_beat ? cap_chan : chan_r;
	assign head       = q_mem_r[cur_chan][q_rd_r[cur_chan]];
	assign keep_now   = sof_beat ? has_desc(q_cnt_r[cap_chan]) : keep_r;
	assign cur_addr   = sof_beat ? head.buf_addr : addr_r;
	assign data_push  = beat && keep_now;
	assign data_pop   = mem_valid && mem_ready;
	assign consume    = beat && cap_eof && keep_now;
	assign desc_ready = (q_cnt_r[desc_chan] != 2'h2) && !(consume && cur_chan == desc_chan);

	generate
		for (genvar c = 0; c < cdw_pkg::NUM_CHAN; c++)
		begin : g_q
			logic push_c;
			logic pop_c;
			assign push_c = desc_valid && desc_ready && (desc_chan == c);
			assign pop_c  = consume && (cur_chan == c);
			always_ff @(posedge mclk or negedge rstn)
			begin
				if (!rstn)
				begin
					q_rd_r[c]  <= '0;
					q_wr_r[c]  <= '0;
					q_cnt_r[c] <= '0;
					q_mem_r[c][0] <= '0;
					q_mem_r[c][1] <= '0;
				end
				else
				begin
					if (push_c)
					begin
						q_mem_r[c][q_wr_r[c]] <= desc_in;
						q_wr_r[c] <= q_wr_r[c] + 1'b1;
					end
					if (pop_c)
						q_rd_r[c] <= q_rd_r[c] + 1'b1;
					q_cnt_r[c] <= q_cnt_r[c] + 2'(push_c) - 2'(pop_c);
				end
			end
		end
	endgenerate

	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_r <= cdw_pkg::CDW_IDLE;
			chan_r  <= '0;
			keep_r  <= 1'b0;
			addr_r  <= cdw_pkg::ADDR_RST;
		end
		else if (beat)
		begin
			chan_r <= cur_chan;
			keep_r <= keep_now;
			addr_r <= cur_addr + (keep_now ? cdw_pkg::ADDR_STEP : '0);
			case (state_r)
				cdw_pkg::CDW_IDLE:  state_r <= (cap_sof && !cap_eof) ? cdw_pkg::CDW_FRAME : cdw_pkg::CDW_IDLE;
				cdw_pkg::CDW_FRAME: state_r <= cap_eof ? cdw_pkg::CDW_IDLE : cdw_pkg::CDW_FRAME;
				default:            state_r <= cdw_pkg::CDW_IDLE;
			endcase
		end
	end

	// buffer lets a memory stall hold words without dropping any
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			bwr_r    <= 1'b0;
			brd_r    <= 1'b0;
			bcnt_r   <= 2'h0;
			buf_r[0] <= '0;
			buf_r[1] <= '0;
		end
		else
		begin
			if (data_push)
			begin
				buf_r[bwr_r] <= '{addr: cur_addr, data: cap_data};
				bwr_r <= !bwr_r;
			end
			if (data_pop)
				brd_r <= !brd_r;
			bcnt_r <= bcnt_r + 2'(data_push) - 2'(data_pop);
		end
	end

	assign mem_valid = (bcnt_r != 2'h0);
	assign mem_out   = buf_r[brd_r];

	// write-back carries the consumed descriptor's buffer address with the captured width and height, never a synthesized one
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			wb_valid_r <= 1'b0;
			wb_r       <= '0;
			drop_r     <= 1'b0;
		end
		else
		begin
			drop_r <= beat && cap_eof && !keep_now;
			if (consume)
			begin
				wb_valid_r <= 1'b1;
				wb_r.chan  <= cur_chan;
				wb_r.desc  <= '{buf_addr: head.buf_addr, width: cap_width, height: cap_height};
			end
			else if (wb_ready)
				wb_valid_r <= 1'b0;
		end
	end

	assign wb_valid   = wb_valid_r;
	assign wb_out     = wb_r;
	assign drop_pulse = drop_r;

	wb_drop_a: assert property (@(posedge mclk) disable iff (!rstn)
		(beat && cap_eof && !keep_now && !(wb_valid_r && !wb_ready)) |=> !wb_valid)
		else $error("write-back issued for a dropped frame");
	drop_data_a: assert property (@(posedge mclk) disable iff (!rstn)
		(beat && !keep_now) |=> $stable(bwr_r))
		else $error("dropped frame data entered the buffer");
	wb_after_eof_a: assert property (@(posedge mclk) disable iff (!rstn)
		consume |=> (wb_valid && wb_out.chan == $past(cur_chan)))
		else $error("consumed descriptor not written back");
	wb_addr_a: assert property (@(posedge mclk) disable iff (!rstn)
		consume |=> (wb_out.desc.buf_addr == $past(head.buf_addr)))
		else $error("write-back address differs from descriptor");
	data_addr_a: assert property (@(posedge mclk) disable iff (!rstn)
		(sof_beat && keep_now && bcnt_r == 2'h0) |=> (mem_valid && mem_out.addr == $past(head.buf_addr)))
		else $error("frame data not sent to descriptor buffer");
	queue_order_a: assert property (@(posedge mclk) disable iff (!rstn)
		consume |=> (q_rd_r[$past(cur_chan)] != $past(q_rd_r[cur_chan])))
		else $error("queue head did not advance in order");
	wb_hold_a: assert property (@(posedge mclk) disable iff (!rstn)
		(wb_valid && !wb_ready) |=> (wb_valid && $stable(wb_out)))
		else $error("write-back dropped under stall");
	buf_stall_a: assert property (@(posedge mclk) disable iff (!rstn)
		(mem_valid && !mem_ready) |=> (mem_valid && $stable(mem_out)))
		else $error("memory word lost under stall");

	frame_kept_c:  cover property (@(posedge mclk) disable iff (!rstn) consume ##1 wb_valid);
	frame_drop_c:  cover property (@(posedge mclk) disable iff (!rstn) drop_pulse);
	buf_full_c:    cover property (@(posedge mclk) disable iff (!rstn) buf_full && !mem_ready);
	queue_two_c:   cover property (@(posedge mclk) disable iff (!rstn) q_cnt_r[0] == 2'h2);
	frame_long_c:  cover property (@(posedge mclk) disable iff (!rstn) state_r == cdw_pkg::CDW_FRAME && consume);
endmodule : cdw_engine

// File: core/cdw_pkg.sv
// package for the capture descriptor write-back engine
package cdw_pkg;
	localparam int CHAN_W        = 2;
	localparam int NUM_CHAN      = 4;
	localparam int ADDR_W        = 32;
	localparam int SIZE_W        = 16;
	localparam int DATA_W        = 32;
	localparam int QUEUE_DEPTH   = 2;
	localparam int QPTR_W        = 1;
	localparam int QCNT_W        = 2;
	localparam int BUF_DEPTH     = 2;
	localparam logic [ADDR_W-1:0] ADDR_RST = 32'h0000_0000;
	localparam logic [SIZE_W-1:0] SIZE_RST = 16'h0000;
	// byte distance between consecutive frame words in the target buffer
	localparam logic [ADDR_W-1:0] ADDR_STEP = 32'h0000_0004;

	// descriptor as queued by software and as written back
	typedef struct packed {
		logic [ADDR_W-1:0] buf_addr;
		logic [SIZE_W-1:0] width;
		logic [SIZE_W-1:0] height;
	} cdw_desc_t;

	// write-back record with its channel
	typedef struct packed {
		logic [CHAN_W-1:0] chan;
		cdw_desc_t         desc;
	} cdw_wb_t;

	// frame data word on its way to memory
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} cdw_mem_t;

	typedef enum logic [0:0] {
		CDW_IDLE  = 1'b0,
		CDW_FRAME = 1'b1
	} cdw_state_t;
endpackage : cdw_pkg

// File: verification/cdw_host_model.sv
// host memory model that sinks frame words and write-back records
`timescale 1ns/1ps
module cdw_host_model (
	// clock and reset
	input  wire logic              mclk,
	input  wire logic              rstn,
	// stall control
	input  wire logic              slow,
	// frame data
	input  wire logic              mem_valid,
	output logic                   mem_ready,
	input  wire cdw_pkg::cdw_mem_t mem_out,
	// write-back
	input  wire logic              wb_valid,
	output logic                   wb_ready,
	input  wire cdw_pkg::cdw_wb_t  wb_out
);
	cdw_pkg::cdw_mem_t memq[$];
	cdw_pkg::cdw_wb_t  wbq[$];
	logic              tick_r;
	int                spurious = 0;
	// last buffer address seen per channel, to spot a 1x1 record that repeats it
	logic [cdw_pkg::ADDR_W-1:0] last_addr [cdw_pkg::NUM_CHAN];
	always_ff @(posedge mclk or negedge rstn)
		if (!rstn)
			tick_r <= 1'b0;
		else
			tick_r <= ~tick_r;
	// slow mode takes every other cycle so the two-entry buffer fills up
	assign mem_ready = !slow || tick_r;
	assign wb_ready  = !slow || !tick_r;
	always @(posedge mclk)
	begin
		if (mem_valid === 1'b1 && mem_ready)
			memq.push_back(mem_out);
		if (wb_valid === 1'b1 && wb_ready)
		begin
			if (wb_out.desc.width == 16'h0001 && wb_out.desc.height == 16'h0001
				&& wb_out.desc.buf_addr == last_addr[wb_out.chan])
				spurious++;
			last_addr[wb_out.chan] = wb_out.desc.buf_addr;
			wbq.push_back(wb_out);
		end
	end
endmodule : cdw_host_model

// File: verification/tb.sv
// self-checking bench for the capture descriptor write-back engine
`timescale 1ns/1ps
module tb;
	logic mclk, rstn, desc_valid, desc_ready, cap_valid, cap_ready, cap_sof, cap_eof, slow;
	logic mem_valid, mem_ready, wb_valid, wb_ready, drop_pulse;
	logic [cdw_pkg::CHAN_W-1:0] desc_chan, cap_chan;
	logic [cdw_pkg::DATA_W-1:0] cap_data;
	logic [cdw_pkg::SIZE_W-1:0] cap_width, cap_height;
	cdw_pkg::cdw_desc_t         desc_in;
	cdw_pkg::cdw_mem_t          mem_out;
	cdw_pkg::cdw_wb_t           wb_out;
	int fail_count = 0;
	int checks = 0;
	int drops = 0;
	int stalls = 0;
	cdw_engine i_cdw_engine (.mclk(mclk), .rstn(rstn), .desc_valid(desc_valid), .desc_ready(desc_ready),
		.desc_chan(desc_chan), .desc_in(desc_in), .cap_valid(cap_valid), .cap_ready(cap_ready),
		.cap_chan(cap_chan), .cap_sof(cap_sof), .cap_eof(cap_eof), .cap_data(cap_data),
		.cap_width(cap_width), .cap_height(cap_height), .mem_valid(mem_valid), .mem_ready(mem_ready),
		.mem_out(mem_out), .wb_valid(wb_valid), .wb_ready(wb_ready), .wb_out(wb_out), .drop_pulse(drop_pulse));
	cdw_host_model i_cdw_host_model (.mclk(mclk), .rstn(rstn), .slow(slow), .mem_valid(mem_valid),
		.mem_ready(mem_ready), .mem_out(mem_out), .wb_valid(wb_valid), .wb_ready(wb_ready), .wb_out(wb_out));
	initial
	begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	always @(posedge mclk)
	begin
		if (drop_pulse === 1'b1)
			drops++;
		if (cap_valid && cap_ready !== 1'b1)
			stalls++;
	end
	task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
		checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic put_desc(input logic [1:0] ch, input logic [31:0] a);
		desc_chan = ch;
		desc_in = '{a, 16'h0000, 16'h0000};
		desc_valid = 1'b1;
		while (desc_ready !== 1'b1)
		begin
			@(posedge mclk);
			#1;
		end
		@(posedge mclk);
		#1;
		desc_valid = 1'b0;
		@(posedge mclk);
		#1;
	endtask : put_desc
	task automatic frame(input logic [1:0] ch, input int n, input logic [31:0] d);
		for (int i = 0; i < n; i++)
		begin
			cap_chan = ch;
			cap_sof = (i == 0);
			cap_eof = (i == n - 1);
			cap_data = d + i;
			cap_width = 16'(n);
			cap_height = 16'h0003;
			cap_valid = 1'b1;
			while (cap_ready !== 1'b1)
			begin
				@(posedge mclk);
				#1;
			end
			@(posedge mclk);
			#1;
		end
		cap_valid = 1'b0;
		repeat (16) @(posedge mclk);
		#1;
	endtask : frame
	task automatic expect_kept(input logic [1:0] ch, input int n, input logic [31:0] d, input logic [31:0] a);
		cdw_pkg::cdw_mem_t m;
		cdw_pkg::cdw_wb_t  w;
		check("word count", n, i_cdw_host_model.memq.size());
		check("wb count", 1, i_cdw_host_model.wbq.size());
		for (int i = 0; i < n && i_cdw_host_model.memq.size() > 0; i++)
		begin
			m = i_cdw_host_model.memq.pop_front();
			check("word addr", a + 4 * i, m.addr);
			check("word data", d + i, m.data);
		end
		if (i_cdw_host_model.wbq.size() > 0)
		begin
			w = i_cdw_host_model.wbq.pop_front();
			check("wb chan", ch, w.chan);
			check("wb addr", a, w.desc.buf_addr);
			check("wb size", {16'(n), 16'h0003}, {w.desc.width, w.desc.height});
		end
	endtask : expect_kept
	task automatic t_kept_stalled;
		put_desc(2'h0, 32'h1000_0000);
		put_desc(2'h0, 32'h2000_0000);
		frame(2'h0, 2, 32'hA000_0000);
		expect_kept(2'h0, 2, 32'hA000_0000, 32'h1000_0000);
		put_desc(2'h0, 32'h3000_0000);
		slow = 1'b1;
		frame(2'h0, 6, 32'hB000_0000);
		slow = 1'b0;
		check("stalled", 1, stalls > 0);
		expect_kept(2'h0, 6, 32'hB000_0000, 32'h2000_0000);
	endtask : t_kept_stalled
	task automatic t_drop;
		frame(2'h1, 3, 32'hC000_0000);
		check("dropped words", 0, i_cdw_host_model.memq.size());
		check("dropped wb", 0, i_cdw_host_model.wbq.size());
		check("drop pulse", 1, drops);
		frame(2'h0, 1, 32'hD000_0000);
		expect_kept(2'h0, 1, 32'hD000_0000, 32'h3000_0000);
		frame(2'h0, 2, 32'hE000_0000);
		check("empty words", 0, i_cdw_host_model.memq.size());
		check("spurious wb", 0, i_cdw_host_model.wbq.size());
		check("drop pulses", 2, drops);
		check("spurious records", 0, i_cdw_host_model.spurious);
	endtask : t_drop
	// a mid-run reset must empty the descriptor queues
	task automatic t_reset;
		put_desc(2'h2, 32'h4000_0000);
		put_desc(2'h2, 32'h5000_0000);
		check("full desc_ready", 0, desc_ready);
		rstn = 1'b0;
		@(posedge mclk);
		#1;
		rstn = 1'b1;
		check("reset desc_ready", 1, desc_ready);
		check("reset cap_ready", 1, cap_ready);
		check("reset mem_valid", 0, mem_valid);
		check("reset wb_valid", 0, wb_valid);
		frame(2'h2, 1, 32'hF000_0000);
		check("reset words", 0, i_cdw_host_model.memq.size());
		check("reset wb", 0, i_cdw_host_model.wbq.size());
		check("reset drops", 3, drops);
	endtask : t_reset
	task automatic print_verdict;
		if (fail_count == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : print_verdict
	initial
	begin
		#100000;
		fail_count++;
		print_verdict();
	end
	initial
	begin
		{rstn, desc_valid, cap_valid, cap_sof, cap_eof, slow} = 6'h00;
		{desc_chan, cap_chan, cap_data, cap_width, cap_height} = '0;
		desc_in = '0;
		repeat (6) @(posedge mclk);
		#1;
		rstn = 1'b1;
		t_kept_stalled();
		t_drop();
		t_reset();
		print_verdict();
	end
endmodule : tb
